/* frame_source.sv */
// far-end sender that hands received frames to the filter
`timescale 1ns/1ns
`default_nettype none
module frame_source (
  input wire logic pclk,
  output logic [1:0] rx_done = 2'h0,
  output logic [15:0] rx_data = 16'h0,
  output logic [1:0] rx_ninth = 2'h0
);
  // stale byte is inverted after the pulse so it never matches by accident
  task send(input int c, input logic [7:0] d, input logic n);
    rx_done <= 2'h1 << c;
    rx_data <= {d, d};
    rx_ninth <= {n, n};
    @(posedge pclk);
    rx_done <= 2'h0;
    rx_data <= ~{d, d};
    rx_ninth <= ~{n, n};
  endtask
endmodule
`default_nettype wire

/* uamb_checker.sv */
// port assertions for the address filter and baud select block
`timescale 1ns/1ns
`default_nettype none
module uamb_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [1:0] rx_done,
  input wire logic timer1_tick,
  input wire logic timer2_tick,
  input wire logic [1:0] gen_tick,
  input wire logic [1:0] tx_bit_clk,
  input wire logic [1:0] rx_bit_clk,
  input wire logic [1:0] receive_flag,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  read_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  error_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  irq_cause_a: assert property (irq |-> receive_flag != 2'h0) else $error("stray irq");
  flag_cause_a: assert property (((receive_flag & ~$past(receive_flag)) & ~$past(rx_done)) == 2'h0)
    else $error("flag without frame");
  tx_source_a: assert property ((tx_bit_clk & ~($past({2{timer1_tick | timer2_tick}} | gen_tick))) == 2'h0)
    else $error("tx clock without tick");
  rx_source_a: assert property ((rx_bit_clk & ~($past({2{timer1_tick | timer2_tick}} | gen_tick))) == 2'h0)
    else $error("rx clock without tick");
endmodule
bind uart_address_match_and_baud_select uamb_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .prdata, .rx_done, .timer1_tick, .timer2_tick, .gen_tick, .tx_bit_clk, .rx_bit_clk, .receive_flag, .irq);
`default_nettype wire

/* uart_addr_defs.vh */
// register offsets, field positions and reset values for the address filter and baud select block
`ifndef UART_ADDR_DEFS_VH
`define UART_ADDR_DEFS_VH

// register indices as printed; byte address is four times the index
`define IDX_UART0_OWN_ADDRESS 8'hA9
`define IDX_UART1_OWN_ADDRESS 8'hAA
`define IDX_UART0_ADDRESS_MASK 8'hB9
`define IDX_UART1_ADDRESS_MASK 8'hBA
`define IDX_CH0_CONTROL 8'hC0
`define IDX_CH1_CONTROL 8'hC1
`define IDX_CLK_SELECT 8'hC2
`define IDX_IRQ_STATUS 8'hC3
`define IDX_IRQ_ENABLE 8'hC4
`define IDX_IRQ_CLEAR 8'hC5
`define IDX_CLK_STATUS 8'hC6

// channel control fields
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 1
`define CTL_MPE_BIT 2
`define CTL_W 3

// clock select fields
`define SEL_TX_T2 0
`define SEL_RX_T2 1
`define SEL_CH0_TX_GEN 2
`define SEL_CH0_RX_GEN 3
`define SEL_CH1_TX_GEN 4
`define SEL_CH1_RX_GEN 5
`define SEL_W 6

// uart modes
`define MODE_SHIFT 2'h0
`define MODE_8BIT 2'h1
`define MODE_9BIT_FIXED 2'h2
`define MODE_9BIT_VAR 2'h3

// clock source codes on the status readback
`define SRC_TIMER1 2'h0
`define SRC_TIMER2 2'h1
`define SRC_INTGEN 2'h2

`define ADDR_RESET 8'h00
`define IRQ_W 2
`define PADDR_IDX_LSB 2
`define PADDR_IDX_MSB 9

`endif

/* uart_address_match_and_baud_select.v */
// receive address filter and baud clock source selection for two uart channels
// Summary of operation
// - address filtering active exactly while the channel's multiprocessor enable is set and its mode is not shift mode 0
// - when filtering, receive flag and interrupt set only for a matching address frame
// - mode 1 filtering uses stop bit as ninth bit; flag needs match and valid stop
// - in shift-register mode 0 the multiprocessor enable has no effect
// - individual match compares received address to own address only where mask is 1
// - broadcast match compares against own OR mask; zero bits of that are ignored
// - either individual or broadcast match accepts the frame
// - reset clears own address and mask so every address matches
// - channel 0 tx clock: internal generator, else timer 2 if selected, else timer 1
// - channel 0 rx clock: internal generator, else timer 2 if selected, else timer 1
// - tx and rx sources are selected independently per channel
// - channel 1 tx: own generator select, else shared timer-2 tx select
// - channel 1 rx: own generator select, else shared timer-2 rx select
// - multiprocessor enable works in modes 2, 3 and optionally mode 1
`timescale 1ns/1ns
`default_nettype none
`include "uart_addr_defs.vh"

module uart_address_match_and_baud_select (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // received frame from each channel's shift logic, same clock
  input wire [1:0] rx_done,
  input wire [15:0] rx_data,
  input wire [1:0] rx_ninth,
  // baud ticks from timer 1, timer 2 and the two internal generators
  input wire timer1_tick,
  input wire timer2_tick,
  input wire [1:0] gen_tick,
  output reg [1:0] tx_bit_clk,
  output reg [1:0] rx_bit_clk,
  output reg [1:0] receive_flag,
  output reg irq
);

  reg [7:0] own_slave_address [0:1];
  reg [7:0] slave_address_mask [0:1];
  reg [`CTL_W-1:0] serial_control [0:1];
  reg [`SEL_W-1:0] clk_select;
  reg [`IRQ_W-1:0] irq_status;
  reg [`IRQ_W-1:0] irq_enable;
  reg [`IRQ_W-1:0] next_irq_status;
  reg [`IRQ_W-1:0] irq_clear;
  // one driver per bit: the generate loop assigns each channel's slice
  wire [`IRQ_W-1:0] accept;
  wire [1:0] tx_sel_tick;
  wire [1:0] rx_sel_tick;
  wire [7:0] idx = paddr[`PADDR_IDX_MSB:`PADDR_IDX_LSB];
  wire access = psel & penable;
  wire wr = access & pwrite;
  integer i;

  // chooses a source: internal generator wins, then timer 2, then timer 1
  function [1:0] pick_src;
    input gen_sel;
    input t2_sel;
    begin
      if (gen_sel) begin
        pick_src = `SRC_INTGEN;
      end else if (t2_sel) begin
        pick_src = `SRC_TIMER2;
      end else begin
        pick_src = `SRC_TIMER1;
      end
    end
  endfunction

  function tick_of;
    input [1:0] src;
    input g;
    input t1;
    input t2;
    begin
      case (src)
        `SRC_INTGEN: tick_of = g;
        `SRC_TIMER2: tick_of = t2;
        default: tick_of = t1;
      endcase
    end
  endfunction

  // masked compare; a zero mask bit is a don't-care in the individual match, a zero bit of own OR mask in the broadcast match
  function addr_match;
    input [7:0] rx;
    input [7:0] own;
    input [7:0] mask;
    reg [7:0] bcast;
    reg given_hit;
    reg bcast_hit;
    begin
      bcast = own | mask;
      given_hit = ((rx ^ own) & mask) == 8'h00;
      bcast_hit = ((rx ^ bcast) & bcast) == 8'h00;
      addr_match = given_hit | bcast_hit;
    end
  endfunction

  wire [1:0] src_tx [0:1];
  wire [1:0] src_rx [0:1];
  assign src_tx[0] = pick_src(clk_select[`SEL_CH0_TX_GEN], clk_select[`SEL_TX_T2]);
  assign src_rx[0] = pick_src(clk_select[`SEL_CH0_RX_GEN], clk_select[`SEL_RX_T2]);
  assign src_tx[1] = pick_src(clk_select[`SEL_CH1_TX_GEN], clk_select[`SEL_TX_T2]);
  assign src_rx[1] = pick_src(clk_select[`SEL_CH1_RX_GEN], clk_select[`SEL_RX_T2]);

  // per channel frame acceptance
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : chan
      wire [1:0] mode = serial_control[c][`CTL_MODE_MSB:`CTL_MODE_LSB];
      // mode 0 ignores the enable bit entirely
      wire filt = serial_control[c][`CTL_MPE_BIT] & (mode != `MODE_SHIFT);
      wire hit = addr_match(rx_data[c*8+7:c*8], own_slave_address[c], slave_address_mask[c]);
      // in mode 1 the ninth input carries the stop bit; in 2/3 the ninth data bit
      assign accept[c] = filt ? (rx_done[c] & rx_ninth[c] & hit) : rx_done[c];
      assign tx_sel_tick[c] = tick_of(src_tx[c], gen_tick[c], timer1_tick, timer2_tick);
      assign rx_sel_tick[c] = tick_of(src_rx[c], gen_tick[c], timer1_tick, timer2_tick);
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_clk <= 2'b00;
      rx_bit_clk <= 2'b00;
    end else begin
      tx_bit_clk <= tx_sel_tick;
      rx_bit_clk <= rx_sel_tick;
    end
  end

  always @* begin
    irq_clear = {`IRQ_W{1'b0}};
    if (wr && idx == `IDX_IRQ_CLEAR) begin
      irq_clear = pwdata[`IRQ_W-1:0];
    end
    // a new frame in the clearing cycle wins over the clear
    next_irq_status = (irq_status & ~irq_clear) | accept;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 2; i = i + 1) begin
        own_slave_address[i] <= `ADDR_RESET;
        slave_address_mask[i] <= `ADDR_RESET;
        serial_control[i] <= {`CTL_W{1'b0}};
      end
      clk_select <= {`SEL_W{1'b0}};
      irq_status <= {`IRQ_W{1'b0}};
      irq_enable <= {`IRQ_W{1'b0}};
      receive_flag <= 2'b00;
      irq <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      receive_flag <= next_irq_status;
      irq <= |(next_irq_status & irq_enable);
      // answer in the cycle after the first access cycle; pready is a one-cycle pulse
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready) begin
        case (idx)
          `IDX_UART0_OWN_ADDRESS: begin
            if (pwrite) own_slave_address[0] <= pwdata[7:0];
            prdata <= {24'h000000, own_slave_address[0]};
          end
          `IDX_UART1_OWN_ADDRESS: begin
            if (pwrite) own_slave_address[1] <= pwdata[7:0];
            prdata <= {24'h000000, own_slave_address[1]};
          end
          `IDX_UART0_ADDRESS_MASK: begin
            if (pwrite) slave_address_mask[0] <= pwdata[7:0];
            prdata <= {24'h000000, slave_address_mask[0]};
          end
          `IDX_UART1_ADDRESS_MASK: begin
            if (pwrite) slave_address_mask[1] <= pwdata[7:0];
            prdata <= {24'h000000, slave_address_mask[1]};
          end
          `IDX_CH0_CONTROL: begin
            if (pwrite) serial_control[0] <= pwdata[`CTL_W-1:0];
            prdata <= {29'h00000000, serial_control[0]};
          end
          `IDX_CH1_CONTROL: begin
            if (pwrite) serial_control[1] <= pwdata[`CTL_W-1:0];
            prdata <= {29'h00000000, serial_control[1]};
          end
          `IDX_CLK_SELECT: begin
            if (pwrite) clk_select <= pwdata[`SEL_W-1:0];
            prdata <= {26'h0000000, clk_select};
          end
          `IDX_IRQ_STATUS: begin
            prdata <= {30'h00000000, irq_status};
          end
          `IDX_IRQ_ENABLE: begin
            if (pwrite) irq_enable <= pwdata[`IRQ_W-1:0];
            prdata <= {30'h00000000, irq_enable};
          end
          `IDX_IRQ_CLEAR: begin
            prdata <= 32'h00000000;
          end
          `IDX_CLK_STATUS: begin
            prdata <= {24'h000000, src_rx[1], src_tx[1], src_rx[0], src_tx[0]};
          end
          default: begin
            // unmapped index: error answer, nothing stored
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* uart_address_match_and_baud_select_tb.sv */
// bench for the address filter and baud select block
`timescale 1ns/1ns
`default_nettype none
`include "uart_addr_defs.vh"
module uart_address_match_and_baud_select_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [1:0] rx_done, rx_ninth, tx_bit_clk, rx_bit_clk, receive_flag;
  logic [15:0] rx_data;
  logic [3:0] tick = 4'h0, tick_q = 4'h0;
  int fails = 0, samples_checked = 0, cyc = 0;
  uart_address_match_and_baud_select u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_done, .rx_data, .rx_ninth, .timer1_tick(tick[0]), .timer2_tick(tick[1]),
    .gen_tick(tick[3:2]), .tx_bit_clk, .rx_bit_clk, .receive_flag, .irq);
  frame_source u_far (.pclk, .rx_done, .rx_data, .rx_ninth);
  initial begin
    forever #5 pclk = ~pclk;
  end
  // counting ticks walks every source mix so each bit clock path sees traffic
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    tick <= tick + 4'h1;
    tick_q <= tick;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task fr(input int c, input logic [7:0] d, input logic n, input logic e);
    u_far.send(c, d, n);
    @(posedge pclk);
    chk("receive flag", receive_flag[c], e);
    chk("irq", irq, e);
    apb(1'h1, `IDX_IRQ_CLEAR, 32'h3);
  endtask
  task test_regs;
    logic [7:0] idx;
    for (int i = 0; i < 4; i++) begin
      idx = (i[1] ? `IDX_UART0_ADDRESS_MASK : `IDX_UART0_OWN_ADDRESS) + {7'h0, i[0]};
      apb(1'h0, idx, 32'h0);
      chk("address reset", rd, 32'h0);
      apb(1'h1, idx, 32'hFFFFFF5A ^ i);
      apb(1'h0, idx, 32'h0);
      chk("address store", rd, {24'h0, 8'h5A ^ i[7:0]});
      apb(1'h1, idx, 32'h0);
    end
    apb(1'h0, 8'h00, 32'h0);
    chk("unmapped", err, 1'h1);
    $display("register test done");
  endtask
  task test_filter(input int c);
    logic [7:0] ctl;
    ctl = `IDX_CH0_CONTROL + c[7:0];
    apb(1'h1, `IDX_IRQ_ENABLE, 32'h3);
    apb(1'h1, ctl, 32'h2);
    fr(c, 8'h12, 1'h0, 1'h1);
    apb(1'h1, ctl, 32'h7);
    fr(c, 8'h33, 1'h1, 1'h1);
    fr(c, 8'h33, 1'h0, 1'h0);
    apb(1'h1, `IDX_UART0_OWN_ADDRESS + c[7:0], 32'h56);
    apb(1'h1, `IDX_UART0_ADDRESS_MASK + c[7:0], 32'hFC);
    fr(c, 8'h57, 1'h1, 1'h1);
    fr(c, 8'h5A, 1'h1, 1'h0);
    fr(c, 8'hFE, 1'h1, 1'h1);
    fr(c, 8'hFF, 1'h1, 1'h1);
    apb(1'h1, ctl, 32'h5);
    fr(c, 8'h55, 1'h1, 1'h1);
    fr(c, 8'h55, 1'h0, 1'h0);
    apb(1'h1, ctl, 32'h4);
    fr(c, 8'h5A, 1'h0, 1'h1);
    apb(1'h1, ctl, 32'h6);
    fr(c, 8'h5A, 1'h1, 1'h0);
    apb(1'h1, ctl, 32'h0);
    $display("filter test done");
  endtask
  task test_irq;
    apb(1'h1, `IDX_IRQ_ENABLE, 32'h0);
    u_far.send(1, 8'h00, 1'h0);
    @(posedge pclk);
    chk("masked irq", irq, 1'h0);
    apb(1'h0, `IDX_IRQ_STATUS, 32'h0);
    chk("status", rd, 32'h2);
    apb(1'h1, `IDX_IRQ_ENABLE, 32'h2);
    chk("enabled irq", irq, 1'h1);
    apb(1'h1, `IDX_IRQ_CLEAR, 32'h2);
    chk("cleared irq", irq, 1'h0);
    $display("interrupt test done");
  endtask
  function logic [1:0] src(input logic g, input logic t2);
    return g ? `SRC_INTGEN : (t2 ? `SRC_TIMER2 : `SRC_TIMER1);
  endfunction
  // tick expected one cycle late on a bit clock whose source code is s
  function logic tk(input logic [1:0] s, input logic g);
    return s == `SRC_INTGEN ? g : (s == `SRC_TIMER2 ? tick_q[1] : tick_q[0]);
  endfunction
  task test_clk;
    logic [5:0] s;
    for (int i = 0; i < 64; i++) begin
      s = i[5:0];
      apb(1'h1, `IDX_CLK_SELECT, {26'h0, s});
      apb(1'h0, `IDX_CLK_STATUS, 32'h0);
      chk("sources", rd, {24'h0, src(s[5], s[1]), src(s[4], s[0]), src(s[3], s[1]), src(s[2], s[0])});
      @(posedge pclk);
      chk("bit clocks", {rx_bit_clk, tx_bit_clk}, {tk(src(s[5], s[1]), tick_q[3]), tk(src(s[3], s[1]), tick_q[2]),
        tk(src(s[4], s[0]), tick_q[3]), tk(src(s[2], s[0]), tick_q[2])});
    end
    $display("clock select test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    test_regs;
    test_filter(0);
    test_filter(1);
    test_irq;
    test_clk;
    end_of_test;
  end
endmodule
`default_nettype wire
